//--- include/sbx_defs.vh
// operation codes, widths and reset values for the skip / bit-op / branch unit
// included by core files; definitions only
`ifndef SBX_DEFS_VH
`define SBX_DEFS_VH

`define SBX_OP_W          5
`define SBX_OP_NOP        5'h00
`define SBX_OP_EQ_MEM_IMM   5'h01
`define SBX_OP_EQ_ACC_MEM   5'h02
`define SBX_OP_EQ_PAIR_MEM  5'h03
`define SBX_OP_EQ_ACC_REG   5'h04
`define SBX_OP_EQ_PAIR_REGS 5'h05
`define SBX_OP_CARRY_SET    5'h06
`define SBX_OP_CARRY_CLR    5'h07
`define SBX_OP_CARRY_TEST   5'h08
`define SBX_OP_CARRY_INV    5'h09
`define SBX_OP_BIT_ONE    5'h0a
`define SBX_OP_BIT_ZERO   5'h0b
`define SBX_OP_SKIP_TRUE  5'h0c
`define SBX_OP_SKIP_FALSE 5'h0d
`define SBX_OP_SKIP_CLR   5'h0e
`define SBX_OP_CARRY_AND  5'h0f
`define SBX_OP_CARRY_OR   5'h10
`define SBX_OP_CARRY_XOR  5'h11
`define SBX_OP_BR_ABS     5'h12
`define SBX_OP_BR_REL     5'h13
`define SBX_OP_BR_BLOCK   5'h14
`define SBX_OP_BR_TBL_SEC 5'h15
`define SBX_OP_BR_TBL_ACC 5'h16

`define SBX_AM_W          2
`define SBX_AM_DIRECT     2'h0
`define SBX_AM_FIXED      2'h1
`define SBX_AM_PTR_L      2'h2
`define SBX_AM_H_PLUS     2'h3

`define SBX_FIXED_BASE    8'hb0
`define SBX_PC_RESET      13'h0000
`define SBX_CARRY_RESET   1'b0

`define SBX_ST_IDLE       2'h0
`define SBX_ST_READ       2'h1
`define SBX_ST_READ2      2'h2
`define SBX_ST_WRITE      2'h3

`endif

//--- core/sbx_bit_addr.v
// bit address generator for the memory bit forms
// combinational; operand fields come straight from the decoder
`timescale 1ns/1ps
`default_nettype none
`include "sbx_defs.vh"

module sbx_bit_addr (
  input  wire [`SBX_AM_W-1:0] mode,
  input  wire [7:0]           mem_imm,
  input  wire [1:0]           bit_imm,
  input  wire [3:0]           ptr_h,
  input  wire [3:0]           ptr_l,
  output reg  [7:0]           addr,
  output reg  [1:0]           bit_sel
);

  always @* begin
    addr    = mem_imm;
    bit_sel = bit_imm;
    case (mode)
      `SBX_AM_DIRECT: begin
        addr    = mem_imm;
        bit_sel = bit_imm;
      end
      // fixed area: low nibble of operand offsets a fixed window
      `SBX_AM_FIXED: begin
        addr    = `SBX_FIXED_BASE | {4'h0, mem_imm[3:0]};
        bit_sel = bit_imm;
      end
      // pointer form: upper bits of l pick the nibble, low bits the bit
      `SBX_AM_PTR_L: begin
        addr    = {mem_imm[7:2], ptr_l[3:2]};
        bit_sel = ptr_l[1:0];
      end
      `SBX_AM_H_PLUS: begin
        addr    = {ptr_h, mem_imm[3:0]};
        bit_sel = bit_imm;
      end
      default: begin
        addr    = mem_imm;
        bit_sel = bit_imm;
      end
    endcase
  end

endmodule

`default_nettype wire

//--- core/sbx_exec.v
// execution unit: compare-and-skip, carry ops, memory bit ops, branches
// assumes data memory answers a read while the strobe stands, registers supplied by core
`timescale 1ns/1ps
`default_nettype none
`include "sbx_defs.vh"

module sbx_exec #(
  parameter PC_W = 13
) (
  input  wire                 clk,
  input  wire                 resetn,
  input  wire                 op_valid,
  input  wire [`SBX_OP_W-1:0] op_code,
  input  wire [`SBX_AM_W-1:0] op_mode,
  input  wire [3:0]           op_nibble,
  input  wire [7:0]           op_mem,
  input  wire [1:0]           op_bit,
  input  wire [2:0]           op_reg_sel,
  input  wire [2:0]           op_pair_sel,
  input  wire [PC_W-1:0]      op_target,
  input  wire [4:0]           op_rel,
  input  wire [PC_W-1:0]      op_pc,
  input  wire [PC_W-1:0]      op_pc_next,
  input  wire [31:0]          regs_main,
  input  wire [31:0]          regs_alt,
  input  wire [7:0]           pointer_pair,
  input  wire [7:0]           second_pointer_pair,
  input  wire [7:0]           accumulator_pair,
  output wire                 op_ready,
  output reg                  mem_rd,
  output reg                  mem_wr,
  output reg  [7:0]           mem_addr,
  output reg  [3:0]           mem_wdata,
  input  wire [3:0]           mem_rdata,
  output reg                  carry_flag,
  output reg                  pc_load,
  output reg  [PC_W-1:0]      pc_value,
  output reg                  skip_pending
);

  localparam [1:0] ST_IDLE  = `SBX_ST_IDLE;
  localparam [1:0] ST_READ  = `SBX_ST_READ;
  localparam [1:0] ST_READ2 = `SBX_ST_READ2;
  localparam [1:0] ST_WRITE = `SBX_ST_WRITE;

  function [3:0] reg_pick;
    input [31:0] bank;
    input [2:0]  sel;
    begin
      reg_pick = bank[sel*4 +: 4];
    end
  endfunction

  function [3:0] bit_apply;
    input [3:0] data;
    input [1:0] sel;
    input       val;
    reg   [3:0] t;
    begin
      t = data;
      t[sel] = val;
      bit_apply = t;
    end
  endfunction

  reg  [1:0]           state_reg;
  reg  [`SBX_OP_W-1:0] cmd_reg;
  reg  [3:0]           cmp_reg;
  reg  [7:0]           addr_reg;
  reg  [1:0]           bit_reg;
  reg  [3:0]           rdlo_reg;

  wire [7:0] bit_addr;
  wire [1:0] bit_num;

  sbx_bit_addr u_addr (
    .mode    (op_mode),
    .mem_imm (op_mem),
    .bit_imm (op_bit),
    .ptr_h   (pointer_pair[7:4]),
    .ptr_l   (pointer_pair[3:0]),
    .addr    (bit_addr),
    .bit_sel (bit_num)
  );

  // a skipped instruction is swallowed here, so the decoder never stalls on it
  assign op_ready = (state_reg == ST_IDLE);

  wire take     = op_valid && op_ready && !skip_pending;
  wire swallow  = op_valid && op_ready && skip_pending;
  wire [7:0] pair_sel_val = op_pair_sel[2] ?
       {reg_pick(regs_alt, {op_pair_sel[1:0], 1'b1}), reg_pick(regs_alt, {op_pair_sel[1:0], 1'b0})} :
       {reg_pick(regs_main, {op_pair_sel[1:0], 1'b1}), reg_pick(regs_main, {op_pair_sel[1:0], 1'b0})};
  // forward distances held minus one, so five bits span -16..-1 and +1..+16
  wire [PC_W-1:0] rel_ext = op_rel[4] ? {{(PC_W-5){1'b1}}, op_rel} :
                            {{(PC_W-4){1'b0}}, op_rel[3:0]} + {{(PC_W-1){1'b0}}, 1'b1};
  wire mem_bit   = mem_rdata[bit_reg];

  always @(posedge clk) begin
    if (!resetn) begin
      state_reg    <= ST_IDLE;
      cmd_reg      <= `SBX_OP_NOP;
      cmp_reg      <= 4'h0;
      addr_reg     <= 8'h00;
      bit_reg      <= 2'h0;
      rdlo_reg     <= 4'h0;
      mem_rd       <= 1'b0;
      mem_wr       <= 1'b0;
      mem_addr     <= 8'h00;
      mem_wdata    <= 4'h0;
      carry_flag   <= `SBX_CARRY_RESET;
      pc_load      <= 1'b0;
      pc_value     <= `SBX_PC_RESET;
      skip_pending <= 1'b0;
    end else begin
      mem_rd  <= 1'b0;
      mem_wr  <= 1'b0;
      pc_load <= 1'b0;
      if (swallow) begin
        skip_pending <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            cmd_reg <= op_code;
            case (op_code)
              `SBX_OP_EQ_MEM_IMM: begin
                cmp_reg   <= op_nibble;
                mem_addr  <= pointer_pair;
                mem_rd    <= 1'b1;
                state_reg <= ST_READ;
              end
              `SBX_OP_EQ_ACC_MEM: begin
                cmp_reg   <= accumulator_pair[3:0];
                mem_addr  <= pointer_pair;
                mem_rd    <= 1'b1;
                state_reg <= ST_READ;
              end
              `SBX_OP_EQ_PAIR_MEM: begin
                mem_addr  <= {pointer_pair[7:1], 1'b0};
                addr_reg  <= {pointer_pair[7:1], 1'b1};
                mem_rd    <= 1'b1;
                state_reg <= ST_READ;
              end
              `SBX_OP_EQ_ACC_REG:
                skip_pending <= (accumulator_pair[3:0] == reg_pick(regs_main, op_reg_sel));
              `SBX_OP_EQ_PAIR_REGS:
                skip_pending <= (accumulator_pair == pair_sel_val);
              `SBX_OP_CARRY_SET:  carry_flag <= 1'b1;
              `SBX_OP_CARRY_CLR:  carry_flag <= 1'b0;
              `SBX_OP_CARRY_TEST: skip_pending <= carry_flag;
              `SBX_OP_CARRY_INV:  carry_flag <= ~carry_flag;
              `SBX_OP_BIT_ONE, `SBX_OP_BIT_ZERO, `SBX_OP_SKIP_TRUE, `SBX_OP_SKIP_FALSE,
              `SBX_OP_SKIP_CLR, `SBX_OP_CARRY_AND, `SBX_OP_CARRY_OR, `SBX_OP_CARRY_XOR: begin
                mem_addr  <= bit_addr;
                addr_reg  <= bit_addr;
                bit_reg   <= bit_num;
                mem_rd    <= 1'b1;
                state_reg <= ST_READ;
              end
              `SBX_OP_BR_ABS: begin
                pc_value <= op_target;
                pc_load  <= 1'b1;
              end
              `SBX_OP_BR_REL: begin
                pc_value <= op_pc + rel_ext;
                pc_load  <= 1'b1;
              end
              `SBX_OP_BR_BLOCK: begin
                // top bit from the incremented pc, so 0ffe/0fff reach block 1
                pc_value <= {op_pc_next[PC_W-1:12], op_target[11:0]};
                pc_load  <= 1'b1;
              end
              `SBX_OP_BR_TBL_SEC: begin
                pc_value <= {op_pc_next[PC_W-1:8], second_pointer_pair};
                pc_load  <= 1'b1;
              end
              `SBX_OP_BR_TBL_ACC: begin
                pc_value <= {op_pc_next[PC_W-1:8], accumulator_pair};
                pc_load  <= 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        ST_READ: begin
          // read data stands while the strobe issued last edge is high
          state_reg <= ST_IDLE;
          case (cmd_reg)
            `SBX_OP_EQ_MEM_IMM: skip_pending <= (mem_rdata == cmp_reg);
            `SBX_OP_EQ_ACC_MEM: skip_pending <= (mem_rdata == cmp_reg);
            `SBX_OP_EQ_PAIR_MEM: begin
              rdlo_reg  <= mem_rdata;
              mem_addr  <= addr_reg;
              mem_rd    <= 1'b1;
              state_reg <= ST_READ2;
            end
            `SBX_OP_BIT_ONE, `SBX_OP_BIT_ZERO: begin
              mem_addr  <= addr_reg;
              mem_wdata <= bit_apply(mem_rdata, bit_reg, cmd_reg == `SBX_OP_BIT_ONE);
              state_reg <= ST_WRITE;
            end
            `SBX_OP_SKIP_TRUE:  skip_pending <= mem_bit;
            `SBX_OP_SKIP_FALSE: skip_pending <= ~mem_bit;
            `SBX_OP_SKIP_CLR: begin
              skip_pending <= mem_bit;
              mem_addr     <= addr_reg;
              mem_wdata    <= bit_apply(mem_rdata, bit_reg, 1'b0);
              state_reg    <= ST_WRITE;
            end
            `SBX_OP_CARRY_AND: carry_flag <= carry_flag & mem_bit;
            `SBX_OP_CARRY_OR:  carry_flag <= carry_flag | mem_bit;
            `SBX_OP_CARRY_XOR: carry_flag <= carry_flag ^ mem_bit;
            default: begin
            end
          endcase
        end
        ST_READ2: begin
          skip_pending <= (rdlo_reg == accumulator_pair[3:0]) &&
                          (mem_rdata == accumulator_pair[7:4]);
          state_reg    <= ST_IDLE;
        end
        ST_WRITE: begin
          mem_wr    <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- verification/sbx_exec_asserts.sv
// timing checks on the execution unit ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "sbx_defs.vh"

module sbx_exec_chk #(
  parameter PC_W = 13
) (
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic            op_valid,
  input wire logic            op_ready,
  input wire logic [4:0]      op_code,
  input wire logic [1:0]      op_mode,
  input wire logic [7:0]      op_mem,
  input wire logic [1:0]      op_bit,
  input wire logic [PC_W-1:0] op_target,
  input wire logic [PC_W-1:0] op_pc_next,
  input wire logic [7:0]      pointer_pair,
  input wire logic [7:0]      accumulator_pair,
  input wire logic            mem_rd,
  input wire logic            mem_wr,
  input wire logic [7:0]      mem_addr,
  input wire logic [3:0]      mem_wdata,
  input wire logic            carry_flag,
  input wire logic            pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic            skip_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // an accepted op that is not being swallowed
  wire go = op_valid && op_ready && !skip_pending;

  carry_force_a: assert property (
    go && op_code inside {`SBX_OP_CARRY_SET, `SBX_OP_CARRY_CLR}
    |=> carry_flag == ($past(op_code) == `SBX_OP_CARRY_SET))
    else $error("carry force wrong");
  carry_inv_a: assert property (go && op_code == `SBX_OP_CARRY_INV |=> carry_flag != $past(carry_flag))
    else $error("carry not inverted");
  carry_test_a: assert property (go && op_code == `SBX_OP_CARRY_TEST |=> skip_pending == $past(carry_flag))
    else $error("carry test skip wrong");
  br_abs_a: assert property (go && op_code == `SBX_OP_BR_ABS |=> pc_load && pc_value == $past(op_target))
    else $error("absolute target wrong");
  br_block_a: assert property (
    go && op_code == `SBX_OP_BR_BLOCK |=> pc_load && pc_value == {$past(op_pc_next[PC_W-1:12]), $past(op_target[11:0])})
    else $error("block target wrong");
  tbl_acc_a: assert property (
    go && op_code == `SBX_OP_BR_TBL_ACC
    |=> pc_load && pc_value == {$past(op_pc_next[PC_W-1:8]), $past(accumulator_pair)})
    else $error("table target wrong");
  skip_swallow_a: assert property (
    op_valid && op_ready && skip_pending |=> !skip_pending && !pc_load && !mem_rd)
    else $error("skipped op had effect");
  bit_write_a: assert property (
    go && op_mode == `SBX_AM_DIRECT && op_code inside {`SBX_OP_BIT_ONE, `SBX_OP_BIT_ZERO}
    |=> mem_rd && mem_addr == $past(op_mem) ##2 mem_wr && mem_addr == $past(op_mem, 3)
    && mem_wdata[$past(op_bit, 3)] == ($past(op_code, 3) == `SBX_OP_BIT_ONE))
    else $error("bit write wrong");
  pair_addr_a: assert property (
    go && op_code == `SBX_OP_EQ_PAIR_MEM |=> mem_rd && mem_addr == {$past(pointer_pair[7:1]), 1'b0})
    else $error("pair address wrong");
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// random op stream against a reference model, memory modelled here
// assumes sbx_defs.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "sbx_defs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; $display("CHECK FAILED %0t value", $time); end end

module tb_top;
  logic        clk = 0, resetn = 0, op_valid = 0, op_ready, mem_rd, mem_wr, carry_flag, pc_load, skip_pending;
  logic [4:0]  op_code = 0, op_rel = 0;
  logic [1:0]  op_mode = 0, op_bit = 0, bs;
  logic [3:0]  op_nibble = 0, mem_wdata, mem_rdata, mem [256], mm [256];
  logic [7:0]  op_mem = 0, pointer_pair = 0, second_pointer_pair = 0, accumulator_pair = 0, mem_addr, ea;
  logic [2:0]  op_reg_sel = 0, op_pair_sel = 0;
  logic [12:0] op_target = 0, op_pc = 0, op_pc_next = 0, pc_value, last_pc, epc;
  logic [31:0] regs_main = 0, regs_alt = 0;
  logic        carry_m = 0, sk = 0, bv, br;
  integer      seed = 32'ha4df;
  int          error_cnt = 0, comparisons = 0, cycles = 0, pc_cnt = 0, exp_cnt;

  sbx_exec #(.PC_W(13)) dut (.clk, .resetn, .op_valid, .op_code, .op_mode, .op_nibble, .op_mem, .op_bit,
    .op_reg_sel, .op_pair_sel, .op_target, .op_rel, .op_pc, .op_pc_next, .regs_main, .regs_alt, .pointer_pair,
    .second_pointer_pair, .accumulator_pair, .op_ready, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata,
    .carry_flag, .pc_load, .pc_value, .skip_pending);

  always #5 clk = ~clk;

  // read data is valid only while the strobe stands; inverted otherwise
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (pc_load) begin
      last_pc <= pc_value;
      pc_cnt <= pc_cnt + 1;
    end
    if (cycles == 10000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic run_op();
    int n = 0;
    op_valid = 1;
    while (!op_ready && n < 50) begin @(negedge clk); n++; end
    @(negedge clk);
    op_valid = 0;
    while (!op_ready && n < 50) begin @(negedge clk); n++; end
    @(negedge clk);
  endtask

  initial begin
    for (int a = 0; a < 256; a++) begin
      mem[a] = 4'($random(seed));
      mm[a] = mem[a];
    end
    repeat (2) @(negedge clk);
    resetn = 1;
    for (int i = 0; i < 600; i++) begin
      op_code = 5'(1 + {$random(seed)} % 22);
      {op_mode, op_bit, op_nibble, op_mem, op_rel} = 21'($random(seed));
      {op_reg_sel, op_pair_sel, pointer_pair, second_pointer_pair, accumulator_pair} = 30'($random(seed));
      {regs_main, regs_alt} = {$random(seed), $random(seed)};
      {op_target, op_pc} = 26'($random(seed));
      // bias toward the last two addresses of a page and block
      if (op_target[12:10] == 0) op_pc[11:1] = 11'h7ff;
      if (op_rel inside {5'h00, 5'h10}) op_rel = 5'h1f;
      op_pc_next = op_pc + 13'h2;
      if (i % 3 == 0) begin
        accumulator_pair = {mm[{pointer_pair[7:1], 1'b1}], mm[{pointer_pair[7:1], 1'b0}]};
        op_nibble = mm[pointer_pair];
        regs_alt[8 * op_pair_sel[1:0] +: 8] = accumulator_pair;
        regs_main[4 * op_reg_sel +: 4] = accumulator_pair[3:0];
      end
      case (op_mode)
        `SBX_AM_DIRECT: {ea, bs} = {op_mem, op_bit};
        `SBX_AM_FIXED: {ea, bs} = {`SBX_FIXED_BASE + {4'h0, op_mem[3:0]}, op_bit};
        `SBX_AM_PTR_L: {ea, bs} = {op_mem[7:2], pointer_pair[3:0]};
        default: {ea, bs} = {pointer_pair[7:4], op_mem[3:0], op_bit};
      endcase
      bv = mm[ea][bs];
      br = 0;
      if (sk) sk = 0;
      else begin
        case (op_code)
          `SBX_OP_EQ_MEM_IMM: sk = mm[pointer_pair] == op_nibble;
          `SBX_OP_EQ_ACC_MEM: sk = mm[pointer_pair] == accumulator_pair[3:0];
          `SBX_OP_EQ_PAIR_MEM: sk = accumulator_pair == {mm[{pointer_pair[7:1], 1'b1}], mm[{pointer_pair[7:1], 1'b0}]};
          `SBX_OP_EQ_ACC_REG: sk = regs_main[4 * op_reg_sel +: 4] == accumulator_pair[3:0];
          `SBX_OP_EQ_PAIR_REGS: sk = 8'((op_pair_sel[2] ? regs_alt : regs_main) >> (8 * op_pair_sel[1:0])) == accumulator_pair;
          `SBX_OP_CARRY_SET: carry_m = 1;
          `SBX_OP_CARRY_CLR: carry_m = 0;
          `SBX_OP_CARRY_TEST: sk = carry_m;
          `SBX_OP_CARRY_INV: carry_m = !carry_m;
          `SBX_OP_BIT_ONE: mm[ea][bs] = 1;
          `SBX_OP_BIT_ZERO: mm[ea][bs] = 0;
          `SBX_OP_SKIP_TRUE: sk = bv;
          `SBX_OP_SKIP_FALSE: sk = !bv;
          `SBX_OP_SKIP_CLR: {sk, mm[ea][bs]} = {bv, 1'b0};
          `SBX_OP_CARRY_AND: carry_m = carry_m & bv;
          `SBX_OP_CARRY_OR: carry_m = carry_m | bv;
          `SBX_OP_CARRY_XOR: carry_m = carry_m ^ bv;
          `SBX_OP_BR_ABS: epc = op_target;
          `SBX_OP_BR_REL: epc = op_pc + (op_rel[4] ? {8'hff, op_rel} : {9'h000, op_rel[3:0]} + 13'h0001);
          `SBX_OP_BR_BLOCK: epc = {op_pc_next[12], op_target[11:0]};
          `SBX_OP_BR_TBL_SEC: epc = {op_pc_next[12:8], second_pointer_pair};
          default: epc = {op_pc_next[12:8], accumulator_pair};
        endcase
        br = op_code >= `SBX_OP_BR_ABS;
      end
      exp_cnt = pc_cnt + br;
      run_op();
      `CHK(carry_flag, carry_m)
      `CHK(skip_pending, sk)
      `CHK(mem[ea], mm[ea])
      `CHK(pc_cnt, exp_cnt)
      if (br) `CHK(last_pc, epc)
    end
    for (int a = 0; a < 256; a++) `CHK(mem[a], mm[a])
    summarize();
  end
endmodule

bind sbx_exec sbx_exec_chk #(.PC_W(PC_W)) chk (.clk, .resetn, .op_valid, .op_ready, .op_code, .op_mode, .op_mem,
  .op_bit, .op_target, .op_pc_next, .pointer_pair, .accumulator_pair, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
  .carry_flag, .pc_load, .pc_value, .skip_pending);
`default_nettype wire
